// ===== hw/adct_cfg.svh
// Offsets, fields, clock select encodings and timing counts of the conversion timer
// How it works
// [R1] Go flag starts twelve-period conversion
// [R2] Select picks divide 8, 32, 64 or RC
// [R3] Software keeps period at least 1.6 us
// [R4] Two-period gap, capacitor disconnected, after conversion
// [R5] Software waits acquisition time before go
// [R6] Holding capacitor is never discharged
// [R7] RC source only for sleep above 1 MHz
// [R8] Completion loads result, clears go, sets done
// [R9] Clearing go aborts, no result, gap, reacquire
// [R10] RC source waits one instruction cycle first
// [R11] Divider restarts at start, counts twelve periods
`ifndef ADCT_CFG_SVH
`define ADCT_CFG_SVH

// APB byte offsets
`define ADCT_OFS_CTRL 8'h00
`define ADCT_OFS_RESULT 8'h04
`define ADCT_OFS_ISTAT 8'h08
`define ADCT_OFS_IMASK 8'h0C
`define ADCT_OFS_STATUS 8'h10

// Field positions
`define ADCT_CTRL_GO 0
`define ADCT_CTRL_SEL_LO 1
`define ADCT_CTRL_SEL_HI 2
`define ADCT_EV_DONE 0
`define ADCT_EV_ABORT 1

// Clock select encodings and divider last counts
`define ADCT_SEL_DIV8 2'h0
`define ADCT_SEL_DIV32 2'h1
`define ADCT_SEL_DIV64 2'h2
`define ADCT_SEL_RC 2'h3
`define ADCT_DIV8_LAST 10'h007
`define ADCT_DIV32_LAST 10'h01F
`define ADCT_DIV64_LAST 10'h03F

// Timing
`define ADCT_CLK_MHZ 100
`define ADCT_RC_TAD_NS 4000
`define ADCT_RC_TAD_CYC (`ADCT_RC_TAD_NS * `ADCT_CLK_MHZ / 1000)
`define ADCT_TCY_CYC 4
`define ADCT_CONV_TADS 4'hB
`define ADCT_BLANK_TADS 4'h1
`define ADCT_CODE_MSB 10'h200

`endif

// ===== hw/adct_pkg.sv
// Types of the conversion timer
`default_nettype none
package adct_pkg;

    typedef enum logic [1:0] {
        ADCT_ACQ,
        ADCT_RCW,
        ADCT_CONV,
        ADCT_BLANK
    } adct_state_e;

    typedef struct packed {
        adct_state_e st;
        logic go;
        logic [1:0] sel;
        logic [9:0] div;
        logic [3:0] tad_period;
        logic [9:0] code;
        logic [9:0] result;
        logic [1:0] ists;
        logic [1:0] imask;
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
        logic irq;
        logic hold;
    } adct_regs_s;

endpackage
`default_nettype wire

// ===== hw/adct_top.sv
// Conversion timing and sequencing for the successive-approximation converter
//
// Decided for this implementation: the APB slave port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
`include "adct_cfg.svh"

module adct_top #(
    parameter logic [9:0] RC_TAD_CYC = 10'(`ADCT_RC_TAD_CYC),
    parameter logic [9:0] TCY_CYC = 10'(`ADCT_TCY_CYC)
) (
    input wire logic i_clk,
    input wire logic i_sys_rst,
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [7:0] i_paddr,
    input wire logic [31:0] i_pwdata,
    output logic [31:0] o_prdata,
    output logic o_pready,
    output logic o_pslverr,
    input wire logic i_cmp_above,
    output logic [9:0] o_dac_code,
    output logic o_hold_connect,
    output logic o_irq
);

    // ---------------------------------------------
    // Helpers
    // ---------------------------------------------
    function automatic logic [9:0] tad_last(
        input logic [1:0] sel
    );
        case (sel)
            `ADCT_SEL_DIV8: tad_last = `ADCT_DIV8_LAST;
            `ADCT_SEL_DIV32: tad_last = `ADCT_DIV32_LAST;
            `ADCT_SEL_DIV64: tad_last = `ADCT_DIV64_LAST;
            default: tad_last = RC_TAD_CYC - 10'h001;
        endcase
    endfunction

    function automatic logic [32:0] read_reg(
        input logic [7:0] addr,
        input adct_pkg::adct_regs_s s
    );
        read_reg = {1'b1, 32'h0000_0000};
        case (addr)
            `ADCT_OFS_CTRL: read_reg[2:0] = {s.sel, s.go};
            `ADCT_OFS_RESULT: read_reg[9:0] = s.result;
            `ADCT_OFS_ISTAT: read_reg[1:0] = s.ists;
            `ADCT_OFS_IMASK: read_reg[1:0] = s.imask;
            `ADCT_OFS_STATUS: read_reg[2:0] = {s.hold, s.st};
            default: read_reg = 33'h0_0000_0000;
        endcase
    endfunction

    adct_pkg::adct_regs_s s_q;
    adct_pkg::adct_regs_s s_d;
    logic tick;
    logic acc;
    logic fin;
    logic wr_ctrl;
    logic [32:0] rd;
    logic done_ev;
    logic abort_ev;
    logic [3:0] bit_idx;
    logic [1:0] sel_new;

    assign tick = (s_q.div == tad_last(s_q.sel));
    assign acc = i_psel & i_penable;
    assign fin = acc & s_q.pready;
    assign wr_ctrl = fin & i_pwrite & (i_paddr == `ADCT_OFS_CTRL);
    assign rd = read_reg(i_paddr, s_q);
    assign bit_idx = 4'hA - s_q.tad_period;
    assign sel_new = i_pwdata[`ADCT_CTRL_SEL_HI:`ADCT_CTRL_SEL_LO];

    // ---------------------------------------------
    // Next state
    // ---------------------------------------------
    always_comb begin
        s_d = s_q;
        done_ev = 1'b0;
        abort_ev = 1'b0;
        // Free-running period divider
        s_d.div = tick ? 10'h000 : s_q.div + 10'h001; // [R11]

        // APB: one wait state, effects at the completing edge
        s_d.pready = 1'b0;
        s_d.pslverr = 1'b0;
        if (acc && !s_q.pready) begin
            s_d.pready = 1'b1;
            s_d.pslverr = ~rd[32];
            s_d.prdata = i_pwrite ? 32'h0000_0000 : rd[31:0];
        end
        if (wr_ctrl) begin
            s_d.sel = sel_new; // [R2]
        end
        if (fin && i_pwrite && i_paddr == `ADCT_OFS_RESULT) begin
            s_d.result = i_pwdata[9:0];
        end
        if (fin && i_pwrite && i_paddr == `ADCT_OFS_IMASK) begin
            s_d.imask = i_pwdata[1:0];
        end

        case (s_q.st)
            adct_pkg::ADCT_ACQ: begin
                s_d.hold = 1'b1;
                if (wr_ctrl && i_pwdata[`ADCT_CTRL_GO]) begin
                    s_d.go = 1'b1; // [R1]
                    s_d.div = 10'h000; // [R11]
                    s_d.tad_period = 4'h0;
                    if (sel_new == `ADCT_SEL_RC) begin
                        s_d.st = adct_pkg::ADCT_RCW; // [R10]
                    end else begin
                        s_d.st = adct_pkg::ADCT_CONV;
                        s_d.code = `ADCT_CODE_MSB;
                        s_d.hold = 1'b0;
                    end
                end
            end
            adct_pkg::ADCT_RCW: begin
                s_d.div = s_q.div + 10'h001;
                if (wr_ctrl && !i_pwdata[`ADCT_CTRL_GO]) begin
                    s_d.go = 1'b0; // [R9]
                    s_d.st = adct_pkg::ADCT_BLANK;
                    s_d.div = 10'h000;
                    s_d.hold = 1'b0;
                    abort_ev = 1'b1;
                end else if (s_q.div == TCY_CYC - 10'h001) begin
                    s_d.st = adct_pkg::ADCT_CONV; // [R10]
                    s_d.div = 10'h000;
                    s_d.code = `ADCT_CODE_MSB;
                    s_d.hold = 1'b0;
                end
            end
            adct_pkg::ADCT_CONV: begin
                if (wr_ctrl && !i_pwdata[`ADCT_CTRL_GO]) begin
                    // Abort leaves the result untouched
                    s_d.go = 1'b0; // [R9]
                    s_d.st = adct_pkg::ADCT_BLANK;
                    s_d.tad_period = 4'h0;
                    s_d.div = 10'h000;
                    abort_ev = 1'b1;
                end else if (tick) begin
                    if (s_q.tad_period == `ADCT_CONV_TADS) begin
                        s_d.result = s_q.code; // [R8]
                        s_d.go = 1'b0; // [R8]
                        s_d.st = adct_pkg::ADCT_BLANK; // [R1]
                        s_d.tad_period = 4'h0;
                        done_ev = 1'b1; // [R8]
                    end else begin
                        // Periods 1..10 resolve bits 9..0
                        if (s_q.tad_period != 4'h0 && s_q.tad_period != `ADCT_CONV_TADS) begin
                            s_d.code[bit_idx] = i_cmp_above;
                            if (bit_idx != 4'h0) begin
                                s_d.code[bit_idx - 4'h1] = 1'b1;
                            end
                        end
                        s_d.tad_period = s_q.tad_period + 4'h1; // [R11]
                    end
                end
            end
            adct_pkg::ADCT_BLANK: begin
                s_d.hold = 1'b0; // [R4]
                if (tick) begin
                    if (s_q.tad_period == `ADCT_BLANK_TADS) begin
                        // Capacitor keeps its charge; only reconnect
                        s_d.st = adct_pkg::ADCT_ACQ; // [R6]
                        s_d.hold = 1'b1; // [R9]
                        s_d.tad_period = 4'h0;
                    end else begin
                        s_d.tad_period = s_q.tad_period + 4'h1; // [R4]
                    end
                end
            end
            default: begin
                s_d.st = adct_pkg::ADCT_ACQ;
            end
        endcase

        // Sticky events; a new event beats the read-clear
        // Clear only the bits that the read reported, so a late event survives
        if (fin && !i_pwrite && i_paddr == `ADCT_OFS_ISTAT) begin
            s_d.ists = s_q.ists & ~s_q.prdata[1:0];
        end
        s_d.ists[`ADCT_EV_DONE] = s_d.ists[`ADCT_EV_DONE] | done_ev; // [R8]
        s_d.ists[`ADCT_EV_ABORT] = s_d.ists[`ADCT_EV_ABORT] | abort_ev;
        s_d.irq = |(s_d.ists & s_d.imask);
    end

    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            s_q <= '0;
            s_q.hold <= 1'b1;
        end else begin
            s_q <= s_d;
        end
    end

    assign o_prdata = s_q.prdata;
    assign o_pready = s_q.pready;
    assign o_pslverr = s_q.pslverr;
    assign o_dac_code = s_q.code;
    assign o_hold_connect = s_q.hold;
    assign o_irq = s_q.irq;

    // ---------------------------------------------
    // Checks
    // ---------------------------------------------
    logic [7:0] blank_cyc;
    logic [3:0] conv_ticks;
    logic [9:0] since_tick;

    always_ff @(posedge i_clk) begin
        if (i_sys_rst || s_q.st != adct_pkg::ADCT_BLANK) begin
            blank_cyc <= 8'h00;
        end else begin
            blank_cyc <= blank_cyc + 8'h01;
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_sys_rst || s_q.st != adct_pkg::ADCT_CONV) begin
            conv_ticks <= 4'h0;
        end else if (tick) begin
            conv_ticks <= conv_ticks + 4'h1;
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_sys_rst || tick || s_q.st != adct_pkg::ADCT_CONV) begin
            since_tick <= 10'h000;
        end else begin
            since_tick <= since_tick + 10'h001;
        end
    end

    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (i_sys_rst);

    sequence rc_wait_s;
        (s_q.st == adct_pkg::ADCT_RCW) [*4];
    endsequence

    sequence conv_go_s;
        s_q.st == adct_pkg::ADCT_CONV && !o_hold_connect;
    endsequence

    conv_length_a: assert property ( // [R1]
        (s_q.st == adct_pkg::ADCT_CONV && tick && s_q.go
         && s_d.st == adct_pkg::ADCT_BLANK && !abort_ev)
        |-> conv_ticks == 4'hB)
        else $error("conversion did not last twelve periods");

    div8_period_a: assert property ( // [R2]
        (s_q.st == adct_pkg::ADCT_CONV && tick && s_q.sel == 2'h0)
        |-> since_tick == 10'h007)
        else $error("divide by eight period wrong");

    blank_open_a: assert property ( // [R4]
        s_q.st == adct_pkg::ADCT_BLANK |-> !o_hold_connect)
        else $error("capacitor connected during gap");

    blank_len_a: assert property ( // [R4]
        ($past(s_q.st) == adct_pkg::ADCT_BLANK
         && s_q.st == adct_pkg::ADCT_ACQ && s_q.sel == 2'h0
         && $past(s_q.sel) == 2'h0)
        |-> $past(blank_cyc) == 8'h0F)
        else $error("gap not two periods");

    reconnect_acq_a: assert property ( // [R6]
        $rose(o_hold_connect)
        |-> s_q.st == adct_pkg::ADCT_ACQ
            && $past(s_q.st) == adct_pkg::ADCT_BLANK)
        else $error("capacitor reconnected outside acquisition");

    done_flags_a: assert property ( // [R8]
        done_ev |=> !s_q.go && s_q.ists[0]
                    && s_q.result == $past(s_q.code))
        else $error("completion effects missing");

    abort_keep_a: assert property ( // [R9]
        (wr_ctrl && !i_pwdata[0] && s_q.st == adct_pkg::ADCT_CONV)
        |=> s_q.st == adct_pkg::ADCT_BLANK && $stable(s_q.result)
            && !s_q.go)
        else $error("abort handled wrongly");

    rc_delay_a: assert property ( // [R10]
        (s_q.st == adct_pkg::ADCT_ACQ && wr_ctrl && i_pwdata[0]
         && i_pwdata[2:1] == 2'h3)
        |=> rc_wait_s ##1 conv_go_s)
        else $error("RC start delay wrong");

    irq_level_a: assert property (
        o_irq == |(s_q.ists & s_q.imask))
        else $error("interrupt level mismatch");

    ready_pulse_a: assert property (
        o_pready |=> !o_pready)
        else $error("ready stood longer than one cycle");

    conv_open_a: assert property ( // [R1]
        s_q.st == adct_pkg::ADCT_CONV |-> !o_hold_connect)
        else $error("capacitor connected during conversion");

    abort_flag_a: assert property ( // [R9]
        abort_ev |=> s_q.ists[`ADCT_EV_ABORT] && !o_hold_connect)
        else $error("abort event not flagged");

endmodule // adct_top
`default_nettype wire

// ===== tb/adct_ain_model.sv
// Analog input and holding capacitor model facing the conversion timer
`timescale 1ns/1ps
`default_nettype none

// ------------------------------------------------------------
// Held charge and comparator
// ------------------------------------------------------------
module adct_ain_model (
    input wire logic i_clk,
    input wire logic i_hold_connect,
    input wire logic [9:0] i_dac_code,
    input wire logic [9:0] i_vin,
    output logic o_cmp_above
);
    logic [9:0] held_q = 10'h000;

    // Tracks the input only while connected, keeps its charge otherwise
    always_ff @(posedge i_clk) begin
        if (i_hold_connect) begin
            held_q <= i_vin;
        end
    end

    assign o_cmp_above = (held_q >= i_dac_code);
endmodule // adct_ain_model
`default_nettype wire

// ===== tb/adct_top_tb.sv
// Self-checking testbench of the conversion timer
`timescale 1ns/1ps
`default_nettype none

// ------------------------------------------------------------
// Bench top
// ------------------------------------------------------------
module adct_top_tb;
    localparam int RC = 160;
    localparam int TCY = 4;
    logic i_clk = 1'b0;
    logic i_sys_rst = 1'b1;
    logic i_psel = 1'b0;
    logic i_penable = 1'b0;
    logic i_pwrite = 1'b0;
    logic [7:0] i_paddr = 8'h00;
    logic [31:0] i_pwdata = 32'h0000_0000;
    logic [31:0] o_prdata;
    logic o_pready, o_pslverr, cmp, o_hold_connect, o_irq;
    logic [9:0] o_dac_code;
    logic [9:0] vin = 10'h000;
    logic [9:0] v0;
    logic [32:0] expq[$];
    int error_cnt = 0;
    int num_checks = 0;
    int per[4] = '{8, 32, 64, RC};

    adct_top #(.RC_TAD_CYC(10'(RC)), .TCY_CYC(10'(TCY))) dut (
        .i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_psel(i_psel),
        .i_penable(i_penable), .i_pwrite(i_pwrite), .i_paddr(i_paddr),
        .i_pwdata(i_pwdata), .o_prdata(o_prdata), .o_pready(o_pready),
        .o_pslverr(o_pslverr), .i_cmp_above(cmp), .o_dac_code(o_dac_code),
        .o_hold_connect(o_hold_connect), .o_irq(o_irq));

    adct_ain_model ain (.i_clk(i_clk), .i_hold_connect(o_hold_connect),
        .i_dac_code(o_dac_code), .i_vin(vin), .o_cmp_above(cmp));

    initial begin
        forever #5 i_clk = ~i_clk;
    end

    task automatic chk(input string nm, input logic [32:0] seen, input logic [32:0] exp);
        num_checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic close_out();
        $display("checks %0d mismatches %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    // One transfer, then one idle edge so the next setup never overlaps
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int k;
        k = 0;
        i_psel <= 1'b1;
        i_pwrite <= w;
        i_paddr <= a;
        i_pwdata <= d;
        @(posedge i_clk);
        i_penable <= 1'b1;
        do begin
            @(posedge i_clk);
            k++;
        end while (o_pready !== 1'b1 && k < 50);
        if (k >= 50) begin
            error_cnt++;
            close_out();
        end
        i_psel <= 1'b0;
        i_penable <= 1'b0;
        @(posedge i_clk);
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask

    task automatic rd(input logic [7:0] a, input logic [32:0] e);
        expq.push_back(e);
        apb(1'b0, a, 32'h0000_0000);
    endtask

    // Cycles from one edge after the launching write until reconnection
    task automatic wait_hold(input int n);
        int k;
        k = 0;
        while (k < 3000) begin
            @(posedge i_clk);
            if (o_hold_connect === 1'b1) begin
                break;
            end
            k++;
        end
        chk("gap end", 33'(k), 33'(n));
        if (k >= 3000) begin
            close_out();
        end
    endtask

    always @(posedge i_clk) begin
        if (o_pready === 1'b1 && i_psel === 1'b1 && i_pwrite === 1'b0) begin
            if (expq.size() > 0) begin
                chk("read", {o_pslverr, o_prdata}, expq.pop_front());
            end
        end
    end

    initial begin
        void'($urandom(32'h7915D4EF));
        repeat (6) @(posedge i_clk);
        i_sys_rst <= 1'b0;
        rd(8'h10, 33'h0_0000_0004);
        rd(8'h14, 33'h1_0000_0000);
        wr(8'h04, 32'h0000_02A5);
        rd(8'h04, 33'h0_0000_02A5);
        wr(8'h0C, 32'h0000_0001);
        for (int s = 0; s < 4; s++) begin
            v0 = 10'($urandom);
            vin <= v0;
            repeat (20) @(posedge i_clk);
            wr(8'h00, 32'(s * 2 + 1));
            // Capacitor still tracks the input through the RC start delay
            if (s == 3) begin
                repeat (TCY) @(posedge i_clk);
            end
            chk("hold open", 33'(o_hold_connect), 33'h0);
            vin <= ~v0;
            wait_hold(14 * per[s] - 1);
            chk("irq", 33'(o_irq), 33'h1);
            rd(8'h04, 33'(v0));
            rd(8'h08, 33'h1);
            rd(8'h00, 33'(s * 2));
            chk("irq", 33'(o_irq), 33'h0);
        end
        wr(8'h00, 32'h0000_0001);
        repeat (30) @(posedge i_clk);
        wr(8'h00, 32'h0000_0000);
        wait_hold(15);
        chk("irq", 33'(o_irq), 33'h0);
        rd(8'h08, 33'h2);
        rd(8'h04, 33'(v0));
        chk("reads left", 33'(expq.size()), 33'h0);
        close_out();
    end
endmodule // adct_top_tb
`default_nettype wire
